// ---- rtl/lcc_pkg.sv ----
// Constants, carrier types and state codes for the charge cycle controller
// Summary of operation
// - Cycle starting with battery below 2.9V uses trickle current, one tenth of programmed.
// - Battery low for 1.125 hr: declare defective, end cycle, pulse status 2Hz 75%.
// - Battery rising above 2.9V restarts the charge cycle.
// - Shutdown input high or supply absent keeps charger disabled in shutdown.
// - Status output pulls down while a charge cycle runs, barring listed exceptions.
// - Status goes high impedance below tenth current or while charger disabled.
// - Termination timer expiry at 4.5 hrs ends cycle, status high impedance.
// - Tenth current caused by input sag outside voltage mode keeps status pulled down.
// - Each cycle start ramps commanded current up from zero to its full or trickle level; a full-scale ramp takes about 180us.
// - Timer starts only with supply valid, above battery, and leaving shutdown.
// - Power-up or leaving shutdown loads the time limit with 4.5 hours.
// - After termination, recharge comparator is watched through a 2ms filter.
// - Filtered battery below 4.1V after termination starts new cycle, 2.25 hour limit.
// - Recharge cycles pull status down until tenth current or termination.
// - Hot or cold comparator trip enters hold mode.
// - Hold freezes timer and stops charging until temperature is valid again.
// - Hold pulses status 2Hz 25% unless charge finished or battery defective.
// - Grounded thermistor sense disables temperature qualification and hold.
// - Charger stays off while input undervoltage flag is active.
package lcc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
    localparam int unsigned SOFTSTART_US     = 180;
    localparam int unsigned SOFTSTART_CYC    = (CLK_HZ / 1_000_000) * SOFTSTART_US;
    localparam int unsigned MS_PER_SEC       = 1000;
    localparam int unsigned FILTER_MS        = 2;
    localparam int unsigned PULSE_HZ         = 2;
    localparam int unsigned PULSE_PERIOD_MS  = MS_PER_SEC / PULSE_HZ;
    localparam int unsigned DEFECT_DUTY_PCT  = 75;
    localparam int unsigned HOLD_DUTY_PCT    = 25;
    localparam int unsigned DEFECT_LOW_MS    = PULSE_PERIOD_MS * DEFECT_DUTY_PCT / 100;
    localparam int unsigned HOLD_LOW_MS      = PULSE_PERIOD_MS * HOLD_DUTY_PCT / 100;
    localparam int unsigned TIMER_FULL_MIN   = 270;
    localparam int unsigned TIMER_RECHG_MIN  = 135;
    localparam int unsigned TIMER_FULL_S     = TIMER_FULL_MIN * 60;
    localparam int unsigned TIMER_RECHG_S    = TIMER_RECHG_MIN * 60;
    localparam int unsigned TRICKLE_LIMIT_S  = TIMER_FULL_S / 4;

    // ****************************************
    // Widths and levels
    // ****************************************
    localparam int unsigned CYC_W            = 16;
    localparam int unsigned MS_W             = 10;
    localparam int unsigned TIMER_W          = 15;
    localparam int unsigned FILT_W           = 4;
    localparam int unsigned CMD_W            = 8;
    localparam int unsigned TRICKLE_PCT      = 10;
    localparam logic [7:0]  CMD_FULL         = 8'hff;
    localparam logic [7:0]  CMD_TRICKLE      = 8'((255 * TRICKLE_PCT) / 100);
    localparam int unsigned RAMP_STEPS       = 256;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W           = 4;
    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h4;
    localparam logic [3:0]  REG_TIMER        = 4'h8;
    localparam logic [3:0]  REG_TRICKLE      = 4'hc;
    localparam int unsigned CTRL_SHDN_BIT    = 0;
    localparam int unsigned CTRL_NTC_DIS_BIT = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;
    localparam int unsigned ST_STATE_LSB     = 0;
    localparam int unsigned ST_TRICKLE_BIT   = 3;
    localparam int unsigned ST_RECHG_BIT     = 4;
    localparam int unsigned ST_TENTH_BIT     = 5;
    localparam int unsigned ST_CHARGING_BIT  = 6;
    localparam int unsigned ST_PIN_BIT       = 7;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic battery_low;
        logic recharge_low;
        logic input_uv;
        logic cv_mode;
        logic below_tenth;
        logic temp_hot;
        logic temp_cold;
        logic temp_sense_grounded;
    } lcc_flags_type;

    typedef enum logic [2:0] {
        LCC_SHUTDOWN,
        LCC_CHARGE,
        LCC_HOLD,
        LCC_DONE,
        LCC_DEFECT
    } lcc_state_type;

endpackage

// ---- rtl/lcc_charge_ctrl.sv ----
// Charge cycle sequencer with status pin driver and Avalon-MM register slave
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module lcc_charge_ctrl #(
    parameter int unsigned CYC_PER_MS      = lcc_pkg::CYC_PER_MS,
    parameter int unsigned SOFTSTART_CYC   = lcc_pkg::SOFTSTART_CYC,
    parameter int unsigned TIMER_FULL_S    = lcc_pkg::TIMER_FULL_S,
    parameter int unsigned TIMER_RECHG_S   = lcc_pkg::TIMER_RECHG_S,
    parameter int unsigned TRICKLE_LIMIT_S = lcc_pkg::TRICKLE_LIMIT_S
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    input  wire lcc_pkg::lcc_flags_type flags_i,
    input  wire logic                  charger_shutdown_in_i,
    input  wire logic                  charge_status_out_i,
    output logic                       charge_status_out_o,
    output logic                       charge_status_out_oe_o,
    output logic                       charge_enable_o,
    output logic                       trickle_o,
    output logic [7:0]                 current_cmd_o,
    input  wire logic [3:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o
);

    // ****************************************
    // Derived constants
    // ****************************************
    localparam logic [15:0] CYC_LAST     = 16'(CYC_PER_MS - 1);
    localparam logic [9:0]  PERIOD_LAST  = 10'(lcc_pkg::PULSE_PERIOD_MS - 1);
    localparam logic [9:0]  SEC_LAST     = 10'(lcc_pkg::MS_PER_SEC - 1);
    localparam logic [9:0]  DEFECT_LOW   = 10'(lcc_pkg::DEFECT_LOW_MS);
    localparam logic [9:0]  HOLD_LOW     = 10'(lcc_pkg::HOLD_LOW_MS);
    localparam logic [14:0] TIMER_FULL   = 15'(TIMER_FULL_S);
    localparam logic [14:0] TIMER_RECHG  = 15'(TIMER_RECHG_S);
    localparam logic [14:0] TRICKLE_LAST = 15'(TRICKLE_LIMIT_S - 1);
    localparam logic [3:0]  FILT_DONE    = 4'(lcc_pkg::FILTER_MS);
    // Rounded down, but at least 1, so the full ramp takes no longer than the soft-start time when that is 255 cycles or more
    localparam int unsigned RAMP_DIV     = (SOFTSTART_CYC / lcc_pkg::RAMP_STEPS) > 0 ?
                                           (SOFTSTART_CYC / lcc_pkg::RAMP_STEPS) : 1;
    localparam logic [12:0] RAMP_LAST    = 13'(RAMP_DIV - 1);

    // ****************************************
    // Timebase
    // ****************************************
    logic [15:0] cyc_cnt;
    logic [15:0] next_cyc_cnt;
    logic        ms_tick;
    logic        next_ms_tick;
    logic [9:0]  pulse_ms;
    logic [9:0]  next_pulse_ms;
    logic [9:0]  sec_ms;
    logic [9:0]  next_sec_ms;
    logic        sec_tick;
    logic        next_sec_tick;

    always_comb begin
        next_cyc_cnt  = cyc_cnt + 16'h0001;
        next_ms_tick  = 1'b0;
        next_pulse_ms = pulse_ms;
        next_sec_ms   = sec_ms;
        next_sec_tick = 1'b0;
        if (cyc_cnt >= CYC_LAST) begin
            next_cyc_cnt = 16'h0000;
            next_ms_tick = 1'b1;
        end
        if (ms_tick) begin
            next_pulse_ms = (pulse_ms >= PERIOD_LAST) ? 10'h000 : pulse_ms + 10'h001;
            if (sec_ms >= SEC_LAST) begin
                next_sec_ms   = 10'h000;
                next_sec_tick = 1'b1;
            end else begin
                next_sec_ms = sec_ms + 10'h001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cyc_cnt  <= 16'h0000;
            ms_tick  <= 1'b0;
            pulse_ms <= 10'h000;
            sec_ms   <= 10'h000;
            sec_tick <= 1'b0;
        end else begin
            cyc_cnt  <= next_cyc_cnt;
            ms_tick  <= next_ms_tick;
            pulse_ms <= next_pulse_ms;
            sec_ms   <= next_sec_ms;
            sec_tick <= next_sec_tick;
        end
    end

    // ****************************************
    // Charge sequencer
    // ****************************************
    lcc_pkg::lcc_state_type state;
    lcc_pkg::lcc_state_type next_state;
    logic [14:0] timer;
    logic [14:0] next_timer;
    logic [14:0] trickle_s;
    logic [14:0] next_trickle_s;
    logic [3:0]  filt;
    logic [3:0]  next_filt;
    logic        recharge;
    logic        next_recharge;
    logic        tenth;
    logic        next_tenth;
    logic        bat_low_q;
    logic [7:0]  level;
    logic [7:0]  next_level;
    logic [12:0] ramp_div;
    logic [12:0] next_ramp_div;
    logic        next_status_oe;
    logic        status_oe;
    logic        charge_en;
    logic        next_charge_en;
    logic        trickle;
    logic        next_trickle;
    logic [1:0]  ctrl;
    logic        shutdown_req;
    logic        temp_bad;
    logic        bat_rise;
    logic [7:0]  target;

    always_comb begin
        // shutdown pin, soft shutdown or no supply
        shutdown_req   = charger_shutdown_in_i | ctrl[lcc_pkg::CTRL_SHDN_BIT] | flags_i.input_uv;
        temp_bad       = (flags_i.temp_hot | flags_i.temp_cold) & ~flags_i.temp_sense_grounded &
                         ~ctrl[lcc_pkg::CTRL_NTC_DIS_BIT];
        // Delay flop resets low, so a battery that is not low at power-up is not taken as a rise
        bat_rise       = bat_low_q & ~flags_i.battery_low;
        next_state     = state;
        next_timer     = timer;
        next_trickle_s = trickle_s;
        next_filt      = 4'h0;
        next_recharge  = recharge;
        next_tenth     = tenth;
        next_level     = level;
        next_ramp_div  = 13'h0000;
        target         = flags_i.battery_low ? lcc_pkg::CMD_TRICKLE : lcc_pkg::CMD_FULL;
        case (state)
            lcc_pkg::LCC_SHUTDOWN: begin
                next_timer     = TIMER_FULL;
                next_trickle_s = 15'h0000;
                next_recharge  = 1'b0;
                next_tenth     = 1'b0;
                next_level     = 8'h00;
                if (!shutdown_req) begin
                    next_state = lcc_pkg::LCC_CHARGE;
                end
            end
            lcc_pkg::LCC_CHARGE: begin
                // tenth point only counts in voltage mode
                if (flags_i.below_tenth && flags_i.cv_mode) begin
                    next_tenth = 1'b1;
                end
                if (level > target) begin
                    next_level = target;
                end else if (level < target) begin
                    next_ramp_div = ramp_div + 13'h0001;
                    if (ramp_div >= RAMP_LAST) begin
                        next_ramp_div = 13'h0000;
                        next_level    = level + 8'h01;
                    end
                end
                if (sec_tick && timer != 15'h0000) begin
                    next_timer = timer - 15'h0001;
                end
                if (temp_bad) begin
                    next_state = lcc_pkg::LCC_HOLD;
                    next_timer = timer;
                end else if (timer == 15'h0000) begin
                    next_state = lcc_pkg::LCC_DONE;
                end else if (bat_rise) begin
                    next_timer     = TIMER_FULL;
                    next_trickle_s = 15'h0000;
                    next_tenth     = 1'b0;
                    next_recharge  = 1'b0;
                    next_level     = 8'h00;
                    next_ramp_div  = 13'h0000;
                end else if (flags_i.battery_low && sec_tick) begin
                    if (trickle_s >= TRICKLE_LAST) begin
                        next_state = lcc_pkg::LCC_DEFECT;
                    end else begin
                        next_trickle_s = trickle_s + 15'h0001;
                    end
                end
            end
            lcc_pkg::LCC_HOLD: begin
                next_level = 8'h00;
                if (!temp_bad) begin
                    next_state = lcc_pkg::LCC_CHARGE;
                end
            end
            lcc_pkg::LCC_DONE: begin
                next_level = 8'h00;
                // 2ms qualification of the recharge comparator
                if (flags_i.recharge_low) begin
                    next_filt = ms_tick ? filt + 4'h1 : filt;
                end
                if (next_filt >= FILT_DONE) begin
                    next_filt      = 4'h0;
                    next_state     = lcc_pkg::LCC_CHARGE;
                    next_timer     = TIMER_RECHG;
                    next_trickle_s = 15'h0000;
                    next_recharge  = 1'b1;
                    next_tenth     = 1'b0;
                end
            end
            lcc_pkg::LCC_DEFECT: begin
                next_level = 8'h00;
                if (bat_rise) begin
                    next_state     = lcc_pkg::LCC_CHARGE;
                    next_timer     = TIMER_FULL;
                    next_trickle_s = 15'h0000;
                    next_tenth     = 1'b0;
                end
            end
            default: begin
                next_state = lcc_pkg::LCC_SHUTDOWN;
            end
        endcase
        // no cycle starts hot or cold
        if (temp_bad && next_state == lcc_pkg::LCC_CHARGE) begin
            next_state = lcc_pkg::LCC_HOLD;
        end
        if (shutdown_req) begin
            next_state = lcc_pkg::LCC_SHUTDOWN;
        end
        next_trickle   = (next_state == lcc_pkg::LCC_CHARGE) & flags_i.battery_low;
        next_charge_en = (next_state == lcc_pkg::LCC_CHARGE);
        if (next_state != lcc_pkg::LCC_CHARGE) begin
            next_level = 8'h00;
        end
        case (next_state)
            // recharge pulls down until tenth point
            lcc_pkg::LCC_CHARGE: begin
                next_status_oe = ~next_tenth;
            end
            lcc_pkg::LCC_HOLD: begin
                next_status_oe = ~next_tenth & (next_pulse_ms < HOLD_LOW);
            end
            lcc_pkg::LCC_DEFECT: begin
                next_status_oe = (next_pulse_ms < DEFECT_LOW);
            end
            default: begin
                next_status_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state     <= lcc_pkg::LCC_SHUTDOWN;
            timer     <= 15'h0000;
            trickle_s <= 15'h0000;
            filt      <= 4'h0;
            recharge  <= 1'b0;
            tenth     <= 1'b0;
            bat_low_q <= 1'b0;
            level     <= 8'h00;
            ramp_div  <= 13'h0000;
            status_oe <= 1'b0;
            charge_en <= 1'b0;
            trickle   <= 1'b0;
        end else begin
            state     <= next_state;
            timer     <= next_timer;
            trickle_s <= next_trickle_s;
            filt      <= next_filt;
            recharge  <= next_recharge;
            tenth     <= next_tenth;
            bat_low_q <= flags_i.battery_low;
            level     <= next_level;
            ramp_div  <= next_ramp_div;
            status_oe <= next_status_oe;
            charge_en <= next_charge_en;
            trickle   <= next_trickle;
        end
    end

    // Open drain: data stays low, only the enable moves
    assign charge_status_out_o    = 1'b0;
    assign charge_status_out_oe_o = status_oe;
    assign charge_enable_o        = charge_en;
    assign trickle_o              = trickle;
    assign current_cmd_o          = level;

    // ****************************************
    // Register slave
    // ****************************************
    logic        wait_q;
    logic        next_wait;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0]  next_ctrl;

    // One wait cycle per access keeps read data a clean flop output
    always_comb begin
        next_wait  = 1'b1;
        next_rdata = rdata;
        next_ctrl  = ctrl;
        if ((avs_read_i || avs_write_i) && wait_q) begin
            next_wait = 1'b0;
            if (avs_write_i && avs_address_i == lcc_pkg::REG_CTRL && avs_byteenable_i[0]) begin
                next_ctrl = avs_writedata_i[1:0];
            end
            if (avs_read_i) begin
                next_rdata = 32'h0000_0000;
                case (avs_address_i)
                    lcc_pkg::REG_CTRL: begin
                        next_rdata[1:0] = ctrl;
                    end
                    lcc_pkg::REG_STATUS: begin
                        next_rdata[2:0]                      = state;
                        next_rdata[lcc_pkg::ST_TRICKLE_BIT]  = trickle;
                        next_rdata[lcc_pkg::ST_RECHG_BIT]    = recharge;
                        next_rdata[lcc_pkg::ST_TENTH_BIT]    = tenth;
                        next_rdata[lcc_pkg::ST_CHARGING_BIT] = charge_en;
                        next_rdata[lcc_pkg::ST_PIN_BIT]      = charge_status_out_i;
                    end
                    lcc_pkg::REG_TIMER: begin
                        next_rdata[14:0] = timer;
                    end
                    lcc_pkg::REG_TRICKLE: begin
                        next_rdata[14:0] = trickle_s;
                    end
                    default: begin
                        next_rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q <= 1'b1;
            rdata  <= 32'h0000_0000;
            ctrl   <= lcc_pkg::CTRL_RESET;
        end else begin
            wait_q <= next_wait;
            rdata  <= next_rdata;
            ctrl   <= next_ctrl;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata;

endmodule

// ---- sim/lcc_charge_ctrl_assertions.sv ----
// Port-level assertions for the charge cycle controller
`timescale 1ns/1ps
module lcc_charge_ctrl_assertions (
    input wire logic                   sys_clk_i,
    input wire logic                   nrst_i,
    input wire lcc_pkg::lcc_flags_type flags_i,
    input wire logic                   charger_shutdown_in_i,
    input wire logic                   charge_status_out_oe_o,
    input wire logic                   charge_enable_o,
    input wire logic                   trickle_o,
    input wire logic [7:0]             current_cmd_o,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic                   avs_waitrequest_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    shdn_off_a: assert property (charger_shutdown_in_i |=> !charge_enable_o && !charge_status_out_oe_o)
        else $error("charger active in shutdown");
    uv_off_a: assert property (flags_i.input_uv |=> !charge_enable_o && !charge_status_out_oe_o)
        else $error("charger active in undervoltage");
    // Blind to the register bit that disables temperature hold; the bench never sets it
    hold_stop_a: assert property ((flags_i.temp_hot || flags_i.temp_cold) &&
        !flags_i.temp_sense_grounded |=> !charge_enable_o && current_cmd_o == 8'h00)
        else $error("charging while too hot or cold");
    trickle_lvl_a: assert property (trickle_o |-> charge_enable_o && charge_status_out_oe_o
        && current_cmd_o <= lcc_pkg::CMD_TRICKLE) else $error("trickle level wrong");
    trickle_end_a: assert property (!flags_i.battery_low |=> !trickle_o)
        else $error("trickle without low battery");
    ramp_step_a: assert property (current_cmd_o > $past(current_cmd_o) |->
        current_cmd_o == $past(current_cmd_o) + 8'h01) else $error("current ramp jumped");
    ramp_zero_a: assert property ($rose(charge_enable_o) |-> current_cmd_o <= 8'h01)
        else $error("cycle did not start from zero");
    bus_ack_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing wrong");
endmodule

bind lcc_charge_ctrl lcc_charge_ctrl_assertions u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .flags_i(flags_i),
    .charger_shutdown_in_i(charger_shutdown_in_i), .charge_status_out_oe_o(charge_status_out_oe_o),
    .charge_enable_o(charge_enable_o), .trickle_o(trickle_o), .current_cmd_o(current_cmd_o),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o));

// ---- sim/lcc_analog_model.sv ----
// Comparator bank and pulled-up status pin on the charger's far side
`timescale 1ns/1ps
module lcc_analog_model (
    input  wire logic                   sys_clk_i,
    input  wire lcc_pkg::lcc_flags_type level_i,
    input  wire logic                   pin_oe_i,
    output lcc_pkg::lcc_flags_type      flags_o,
    output logic                        pin_o
);
    initial flags_o = '0;
    always @(posedge sys_clk_i) flags_o <= level_i;
    assign pin_o = pin_oe_i ? 1'b0 : 1'b1;
endmodule

// ---- sim/test_lcc_charge_ctrl.sv ----
// Self-checking bench for the charge cycle controller
`timescale 1ns/1ps
module test_lcc_charge_ctrl;
    localparam int MS  = 2;
    localparam int SEC = MS * 1000;
    localparam int PER = MS * 500;
    logic                   sys_clk_i = 1'b0;
    logic                   nrst_i    = 1'b0;
    logic                   shdn      = 1'b0;
    lcc_pkg::lcc_flags_type lvl       = '0;
    lcc_pkg::lcc_flags_type flags;
    logic                   pin, oe, en, trk, rd = 1'b0, wr = 1'b0, wrq, pdat;
    logic [7:0]             cmd;
    logic [3:0]             ad = 4'h0;
    logic [31:0]            wd = 32'h0, rdat, v, tmr;
    int                     n_fail = 0, checked = 0, t0;

    always #20 sys_clk_i = ~sys_clk_i;

    lcc_charge_ctrl #(.CYC_PER_MS(MS), .SOFTSTART_CYC(256), .TIMER_FULL_S(6), .TIMER_RECHG_S(3),
        .TRICKLE_LIMIT_S(2)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .flags_i(flags),
        .charger_shutdown_in_i(shdn), .charge_status_out_i(pin), .charge_status_out_o(pdat),
        .charge_status_out_oe_o(oe), .charge_enable_o(en), .trickle_o(trk), .current_cmd_o(cmd),
        .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq));
    lcc_analog_model u_far (.sys_clk_i(sys_clk_i), .level_i(lvl), .pin_oe_i(oe), .flags_o(flags), .pin_o(pin));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Holds the request until waitrequest is sampled low at a rising edge, then takes the data there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (wrq !== 1'b0 && k < 20);
        if (k >= 20)
            n_fail++;
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic cnt(output int n);
        n = 0;
        repeat (PER) begin
            @(negedge sys_clk_i);
            n += int'(oe === 1'b1);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge sys_clk_i);
        n_fail++;
        give_verdict();
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        settle(3);
        chk("pulldown", 32'(oe), 32'h1);
        chk("pin data", 32'(pdat), 32'h0);
        chk("ramp low", 32'(cmd < 8'h08), 32'h1);
        settle(300);
        chk("ramp full", 32'(cmd), 32'hff);
        bus(1'b0, lcc_pkg::REG_STATUS, 32'h0);
        chk("status", v, 32'h41);
        bus(1'b0, lcc_pkg::REG_TIMER, 32'h0);
        chk("timer load", v, 32'h6);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", v, 32'h0);
        bus(1'b1, lcc_pkg::REG_CTRL, 32'h1);
        settle(2);
        chk("soft off", 32'({en, oe}), 32'h0);
        bus(1'b0, lcc_pkg::REG_STATUS, 32'h0);
        chk("status off", v, 32'h80);
        bus(1'b1, lcc_pkg::REG_CTRL, 32'h0);
        lvl.input_uv <= 1'b1;
        settle(3);
        chk("uv off", 32'(en), 32'h0);
        lvl.input_uv <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_i);
            lvl.temp_hot <= (i == 0);
            lvl.temp_cold <= (i == 1);
            settle(3);
            chk("hold", 32'(en), 32'h0);
            cnt(t0);
            chk("hold pulse", 32'(t0), 32'hfa);
            bus(1'b0, lcc_pkg::REG_TIMER, 32'h0);
            tmr = v;
            settle(SEC);
            bus(1'b0, lcc_pkg::REG_TIMER, 32'h0);
            chk("frozen", v, tmr);
        end
        lvl.temp_cold <= 1'b0;
        settle(3);
        chk("resume", 32'(en), 32'h1);
        lvl.temp_hot <= 1'b1;
        lvl.temp_sense_grounded <= 1'b1;
        settle(5);
        chk("no hold", 32'(en), 32'h1);
        lvl.temp_hot <= 1'b0;
        lvl.below_tenth <= 1'b1;
        settle(3);
        chk("sag pulldown", 32'(oe), 32'h1);
        lvl.cv_mode <= 1'b1;
        settle(3);
        chk("tenth", 32'(oe), 32'h0);
        settle(7 * SEC);
        chk("expired", 32'({en, oe}), 32'h0);
        // Single-cycle dip must be filtered out
        lvl.recharge_low <= 1'b1;
        @(posedge sys_clk_i);
        lvl.recharge_low <= 1'b0;
        settle(10);
        chk("filtered", 32'(en), 32'h0);
        lvl.recharge_low <= 1'b1;
        // A fresh cycle draws current again, so the tenth flag drops
        lvl.below_tenth <= 1'b0;
        settle(10);
        chk("recharge", 32'({en, oe}), 32'h3);
        bus(1'b0, lcc_pkg::REG_STATUS, 32'h0);
        chk("rechg status", v, 32'h51);
        bus(1'b0, lcc_pkg::REG_TIMER, 32'h0);
        chk("rechg timer", v, 32'h3);
        // Only the battery-low flag, the top bit of the flag word
        lvl <= 8'h80;
        shdn <= 1'b1;
        settle(3);
        chk("pin off", 32'(en), 32'h0);
        @(posedge sys_clk_i);
        shdn <= 1'b0;
        settle(40);
        chk("trickle", 32'({trk, cmd}), 32'h119);
        settle(3 * SEC);
        bus(1'b0, lcc_pkg::REG_STATUS, 32'h0);
        chk("defect", 32'({en, v[2:0]}), 32'h4);
        cnt(t0);
        chk("defect pulse", 32'(t0), 32'h2ee);
        @(posedge sys_clk_i);
        shdn <= 1'b1;
        @(posedge sys_clk_i);
        shdn <= 1'b0;
        settle(40);
        chk("restart", 32'(en), 32'h1);
        lvl.battery_low <= 1'b0;
        settle(3);
        chk("rise restart", 32'(cmd < 8'h08), 32'h1);
        give_verdict();
    end
endmodule
